// >>> src/wake_regs_pkg.sv
// Package for the wake pattern, identity, lamp, counter window and PHY register bank.
// Assumes a 16-bit register port with byte addresses on a 12-bit address bus.
package wake_regs_pkg;

   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;

   // Register byte offsets.
   localparam logic [11:0] OFS_WAKE3_CRC_LOW = 12'h250;
   localparam logic [11:0] OFS_WAKE3_CRC_HIGH = 12'h252;
   localparam logic [11:0] OFS_WAKE3_MASK_FIRST = 12'h254;
   localparam logic [11:0] OFS_WAKE3_MASK_SECOND = 12'h256;
   localparam logic [11:0] OFS_WAKE3_MASK_THIRD = 12'h258;
   localparam logic [11:0] OFS_WAKE3_MASK_LAST = 12'h25A;
   localparam logic [11:0] OFS_IDENTITY_AND_RUN = 12'h400;
   localparam logic [11:0] OFS_GLOBAL_LED_CONTROL = 12'h40A;
   localparam logic [11:0] OFS_INDIRECT_COMMAND = 12'h4A0;
   localparam logic [11:0] OFS_INDIRECT_READ_FLAG = 12'h4A2;
   localparam logic [11:0] OFS_INDIRECT_DATA_47_32 = 12'h4A4;
   localparam logic [11:0] OFS_INDIRECT_DATA_SPARE = 12'h4A6;
   localparam logic [11:0] OFS_INDIRECT_DATA_15_0 = 12'h4A8;
   localparam logic [11:0] OFS_INDIRECT_DATA_31_16 = 12'h4AA;
   localparam logic [11:0] OFS_PHY_BASIC_CONTROL = 12'h4D0;
   localparam logic [11:0] OFS_PHY_BASIC_STATUS = 12'h4D2;
   localparam logic [11:0] OFS_PORT_CONTROL_FOUR = 12'h512;

   // Identity fields; the values are arbitrary.
   localparam logic [7:0] FAMILY_ID = 8'h5A;
   localparam logic [3:0] CHIP_ID = 4'h3;
   localparam logic [2:0] REVISION_ID = 3'h1;

   // Indirect command, read flag and lamp mode fields.
   localparam int CMD_READ_BIT = 12;
   localparam logic [1:0] TABLE_COUNTERS = 2'h3;
   localparam int READ_FLAG_BIT = 7;
   localparam int LAMP_HIGH_BIT = 15;
   localparam int LAMP_LOW_BIT = 9;

   // Counter store read latency in clock cycles.
   localparam logic [1:0] COUNTER_READ_CYCLES = 2'h2;

   // Basic control register bit positions, and the spare bit of port control four.
   localparam int BC_FORCE_100 = 13;
   localparam int BC_AN_ENABLE = 12;
   localparam int BC_POWER_DOWN = 11;
   localparam int BC_RESTART_AN = 9;
   localparam int BC_FORCE_FULL = 8;
   localparam int BC_ALT_XOVER = 5;
   localparam int BC_FORCE_MDIX = 4;
   localparam int BC_NO_AUTO_MDIX = 3;
   localparam int BC_NO_FAR_FAULT = 2;
   localparam int BC_NO_TX = 1;
   localparam int BC_NO_LED = 0;
   localparam int BC_SPARE = 14;
   localparam int PC_SPARE = 8;

   // Port control four bit positions of the shared bits.
   localparam int PC_NO_LED = 15;
   localparam int PC_NO_TX = 14;
   localparam int PC_RESTART_AN = 13;
   localparam int PC_NO_FAR_FAULT = 12;
   localparam int PC_POWER_DOWN = 11;
   localparam int PC_NO_AUTO_MDIX = 10;
   localparam int PC_FORCE_MDIX = 9;
   localparam int PC_AN_ENABLE = 7;
   localparam int PC_FORCE_100 = 6;
   localparam int PC_FORCE_FULL = 5;
   localparam logic [4:0] PC_ADVERT_RESET = 5'h1F;

   // Status register bit positions.
   localparam int BS_AN_DONE = 5;
   localparam int BS_FAR_FAULT = 4;
   localparam int BS_AN_CAPABLE = 3;
   localparam int BS_LINK_UP = 2;
   localparam logic [15:0] BS_CAPS = 16'h7800;

   typedef struct packed {
      logic force_100;
      logic an_enable;
      logic power_down;
      logic restart_an;
      logic force_full;
      logic alt_crossover_select;
      logic force_mdix;
      logic no_auto_mdix;
      logic no_far_fault;
      logic no_tx;
      logic no_led;
   } phy_ctrl_t;

   typedef struct packed {
      logic an_done;
      logic far_fault;
      logic link_up;
   } phy_stat_t;

   typedef struct packed {
      logic port_lamp_three;
      logic port_lamp_two;
      logic port_lamp_one;
      logic port_lamp_zero;
   } lamps_t;

endpackage

// >>> src/lamp_mux.sv
// Lamp selection: maps link indications onto four port lamps by mode.
// Assumes level inputs synchronous to the clock; outputs are registered.
`timescale 1ns/1ps
module lamp_mux
   import wake_regs_pkg::*;
(
   input wire logic ref_clk_in, // Clock.
   input wire logic reset_in, // Asynchronous reset, high.
   input wire logic lamp_mode_high_in, // Mode select high.
   input wire logic lamp_mode_low_in, // Mode select low.
   input wire logic lamps_off_in, // Turns every lamp off.
   input wire logic link_in, // Link up.
   input wire logic activity_in, // Traffic seen.
   input wire logic full_duplex_in, // Full duplex.
   input wire logic collision_in, // Collision seen.
   input wire logic speed_100_in, // 100 Mbps.
   output lamps_t lamps_out // Lamps, high is lit.
);
   lamps_t lamps_reg;
   lamps_t lamps_next;

   always_comb begin
      lamps_next = '0;
      unique case ({lamp_mode_high_in, lamp_mode_low_in})
         2'h0: begin
            lamps_next.port_lamp_two = link_in & activity_in;
            lamps_next.port_lamp_one = full_duplex_in | collision_in;
            lamps_next.port_lamp_zero = speed_100_in;
         end
         2'h1: begin
            lamps_next.port_lamp_two = link_in & activity_in & speed_100_in;
            lamps_next.port_lamp_one = link_in & activity_in & ~speed_100_in;
            lamps_next.port_lamp_zero = full_duplex_in;
         end
         2'h2: begin
            lamps_next.port_lamp_three = activity_in;
            lamps_next.port_lamp_two = link_in;
            lamps_next.port_lamp_one = full_duplex_in | collision_in;
            lamps_next.port_lamp_zero = speed_100_in;
         end
         2'h3: begin
            // Mode 11 drives no lamp.
            lamps_next = '0;
         end
      endcase
      if (lamps_off_in) begin
         lamps_next = '0;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         lamps_reg <= '0;
      end else begin
         lamps_reg <= lamps_next;
      end
   end

   assign lamps_out = lamps_reg;
endmodule

// >>> src/counter_store.sv
// Statistics counter store: 48-bit counters read by address with a fixed latency.
// Assumes increments come from the MAC as one-cycle pulses with a counter index.
`timescale 1ns/1ps
module counter_store
   import wake_regs_pkg::*;
(
   input wire logic ref_clk_in, // Clock.
   input wire logic reset_in, // Asynchronous reset, high.
   input wire logic bump_in, // Increment pulse.
   input wire logic [4:0] bump_index_in, // Counter to increment.
   input wire logic read_in, // Read request pulse.
   input wire logic [9:0] read_addr_in, // Counter address.
   output logic [47:0] read_data_out, // Counter value.
   output logic read_done_out // Data valid pulse.
);
   localparam int DEPTH = 32;
   logic [47:0] counters [DEPTH];
   logic [47:0] data_reg;
   logic [1:0] wait_reg;
   logic busy_reg;
   logic done_reg;
   logic [4:0] addr_reg;

   // Counters hold their values across the read, so a read never loses a bump.
   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         for (int i = 0; i < DEPTH; i++) begin
            counters[i] <= '0;
         end
         data_reg <= '0;
         wait_reg <= '0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         addr_reg <= '0;
      end else begin
         done_reg <= 1'b0;
         if (bump_in) begin
            counters[bump_index_in] <= counters[bump_index_in] + 48'h1;
         end
         if (read_in) begin
            busy_reg <= 1'b1;
            wait_reg <= COUNTER_READ_CYCLES;
            addr_reg <= read_addr_in[4:0];
         end else if (busy_reg) begin
            if (wait_reg == 2'h1) begin
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
               data_reg <= counters[addr_reg];
            end
            wait_reg <= wait_reg - 2'h1;
         end
      end
   end

   assign read_data_out = data_reg;
   assign read_done_out = done_reg;
endmodule

// >>> src/wake_regs.sv
// Register bank: wake pattern three, identity and run, lamp mode, counter window, PHY basics.
// Assumes a single-cycle strobe register port; read data stands one cycle after the strobe.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
module wake_regs
   import wake_regs_pkg::*;
(
   input wire logic ref_clk_in, // Clock, 100 MHz.
   input wire logic reset_in, // Asynchronous reset, high.
   input wire logic [11:0] addr_in, // Register byte address.
   input wire logic [15:0] wdata_in, // Write data.
   input wire logic wr_in, // Write strobe.
   input wire logic rd_in, // Read strobe.
   input wire logic bump_in, // Counter increment pulse.
   input wire logic [4:0] bump_index_in, // Counter to increment.
   input phy_stat_t phy_stat_in, // Live PHY status.
   input wire logic activity_in, // Traffic seen.
   input wire logic collision_in, // Collision seen.
   input wire logic speed_100_in, // Link runs at 100 Mbps.
   input wire logic full_duplex_in, // Link runs full duplex.
   output logic [15:0] rdata_out, // Read data, one cycle after the read strobe.
   output logic run_out, // Chip operation enabled.
   output phy_ctrl_t phy_ctrl_out, // PHY control bits.
   output logic [31:0] wake3_crc_out, // Expected CRC of pattern three.
   output logic [63:0] wake3_mask_out, // Byte mask of pattern three.
   output lamps_t lamps_out // Port lamps.
);
   typedef struct packed {
      logic [15:0] rdata;
      logic [31:0] crc;
      logic [63:0] mask;
      logic run;
      logic [15:0] led_ctrl;
      logic [15:0] cmd;
      logic [47:0] data;
      logic reading;
      phy_ctrl_t ctrl;
      logic [4:0] advert;
      logic spare14;
   } state_t;

   state_t state_reg;
   state_t state_next;
   logic launch_read;
   logic [47:0] counter_data;
   logic counter_done;

   function automatic logic [15:0] ctrl_word(input phy_ctrl_t c, input logic spare);
      logic [15:0] w;
      w = '0;
      w[BC_SPARE] = spare;
      w[BC_FORCE_100] = c.force_100;
      w[BC_AN_ENABLE] = c.an_enable;
      w[BC_POWER_DOWN] = c.power_down;
      w[BC_RESTART_AN] = c.restart_an;
      w[BC_FORCE_FULL] = c.force_full;
      w[BC_ALT_XOVER] = c.alt_crossover_select;
      w[BC_FORCE_MDIX] = c.force_mdix;
      w[BC_NO_AUTO_MDIX] = c.no_auto_mdix;
      w[BC_NO_FAR_FAULT] = c.no_far_fault;
      w[BC_NO_TX] = c.no_tx;
      w[BC_NO_LED] = c.no_led;
      return w;
   endfunction

   function automatic logic [15:0] port_word(input phy_ctrl_t c, input logic [4:0] adv,
                                             input logic spare);
      logic [15:0] w;
      w = '0;
      w[PC_NO_LED] = c.no_led;
      w[PC_NO_TX] = c.no_tx;
      w[PC_RESTART_AN] = c.restart_an;
      w[PC_NO_FAR_FAULT] = c.no_far_fault;
      w[PC_POWER_DOWN] = c.power_down;
      w[PC_NO_AUTO_MDIX] = c.no_auto_mdix;
      w[PC_FORCE_MDIX] = c.force_mdix;
      w[PC_SPARE] = spare;
      w[PC_AN_ENABLE] = c.an_enable;
      w[PC_FORCE_100] = c.force_100;
      w[PC_FORCE_FULL] = c.force_full;
      w[4:0] = adv;
      return w;
   endfunction

   always_comb begin
      state_next = state_reg;
      launch_read = 1'b0;
      state_next.rdata = '0;

      if (rd_in) begin
         unique case (addr_in)
            OFS_WAKE3_CRC_LOW: state_next.rdata = state_reg.crc[15:0];
            OFS_WAKE3_CRC_HIGH: state_next.rdata = state_reg.crc[31:16];
            OFS_WAKE3_MASK_FIRST: state_next.rdata = state_reg.mask[15:0];
            OFS_WAKE3_MASK_SECOND: state_next.rdata = state_reg.mask[31:16];
            OFS_WAKE3_MASK_THIRD: state_next.rdata = state_reg.mask[47:32];
            OFS_WAKE3_MASK_LAST: state_next.rdata = state_reg.mask[63:48];
            OFS_IDENTITY_AND_RUN:
               state_next.rdata = {FAMILY_ID, CHIP_ID, REVISION_ID, state_reg.run};
            OFS_GLOBAL_LED_CONTROL: state_next.rdata = state_reg.led_ctrl;
            OFS_INDIRECT_COMMAND: state_next.rdata = state_reg.cmd;
            OFS_INDIRECT_READ_FLAG: state_next.rdata[READ_FLAG_BIT] = state_reg.reading;
            OFS_INDIRECT_DATA_47_32: state_next.rdata = state_reg.data[47:32];
            OFS_INDIRECT_DATA_15_0: state_next.rdata = state_reg.data[15:0];
            OFS_INDIRECT_DATA_31_16: state_next.rdata = state_reg.data[31:16];
            OFS_PHY_BASIC_CONTROL:
               state_next.rdata = ctrl_word(state_reg.ctrl, state_reg.spare14);
            OFS_PHY_BASIC_STATUS: begin
               state_next.rdata = BS_CAPS;
               state_next.rdata[BS_AN_CAPABLE] = 1'b1;
               state_next.rdata[BS_AN_DONE] = phy_stat_in.an_done;
               state_next.rdata[BS_FAR_FAULT] = phy_stat_in.far_fault;
               state_next.rdata[BS_LINK_UP] = phy_stat_in.link_up;
            end
            OFS_PORT_CONTROL_FOUR:
               state_next.rdata = port_word(state_reg.ctrl, state_reg.advert,
                                            state_reg.spare14);
            default: state_next.rdata = '0;
         endcase
      end

      if (wr_in) begin
         unique case (addr_in)
            OFS_WAKE3_CRC_LOW: state_next.crc[15:0] = wdata_in;
            OFS_WAKE3_CRC_HIGH: state_next.crc[31:16] = wdata_in;
            OFS_WAKE3_MASK_FIRST: state_next.mask[15:0] = wdata_in;
            OFS_WAKE3_MASK_SECOND: state_next.mask[31:16] = wdata_in;
            OFS_WAKE3_MASK_THIRD: state_next.mask[47:32] = wdata_in;
            OFS_WAKE3_MASK_LAST: state_next.mask[63:48] = wdata_in;
            OFS_IDENTITY_AND_RUN: state_next.run = wdata_in[0];
            OFS_GLOBAL_LED_CONTROL: state_next.led_ctrl = wdata_in;
            OFS_INDIRECT_COMMAND: begin
               state_next.cmd = wdata_in;
               // Only counter reads are backed; other tables and writes are ignored.
               if (wdata_in[CMD_READ_BIT] && wdata_in[11:10] == TABLE_COUNTERS) begin
                  launch_read = 1'b1;
                  state_next.reading = 1'b1;
               end
            end
            OFS_INDIRECT_DATA_47_32: state_next.data[47:32] = wdata_in;
            OFS_INDIRECT_DATA_15_0: state_next.data[15:0] = wdata_in;
            OFS_INDIRECT_DATA_31_16: state_next.data[31:16] = wdata_in;
            OFS_PHY_BASIC_CONTROL: begin
               state_next.spare14 = wdata_in[BC_SPARE];
               state_next.ctrl.force_100 = wdata_in[BC_FORCE_100];
               state_next.ctrl.an_enable = wdata_in[BC_AN_ENABLE];
               state_next.ctrl.force_full = wdata_in[BC_FORCE_FULL];
               state_next.ctrl.power_down = wdata_in[BC_POWER_DOWN];
               state_next.ctrl.restart_an = wdata_in[BC_RESTART_AN];
               state_next.ctrl.alt_crossover_select = wdata_in[BC_ALT_XOVER];
               state_next.ctrl.force_mdix = wdata_in[BC_FORCE_MDIX];
               state_next.ctrl.no_auto_mdix = wdata_in[BC_NO_AUTO_MDIX];
               state_next.ctrl.no_far_fault = wdata_in[BC_NO_FAR_FAULT];
               state_next.ctrl.no_tx = wdata_in[BC_NO_TX];
               state_next.ctrl.no_led = wdata_in[BC_NO_LED];
            end
            OFS_PORT_CONTROL_FOUR: begin
               state_next.ctrl.no_led = wdata_in[PC_NO_LED];
               state_next.ctrl.no_tx = wdata_in[PC_NO_TX];
               state_next.ctrl.restart_an = wdata_in[PC_RESTART_AN];
               state_next.ctrl.no_far_fault = wdata_in[PC_NO_FAR_FAULT];
               state_next.ctrl.power_down = wdata_in[PC_POWER_DOWN];
               state_next.ctrl.no_auto_mdix = wdata_in[PC_NO_AUTO_MDIX];
               state_next.ctrl.force_mdix = wdata_in[PC_FORCE_MDIX];
               state_next.spare14 = wdata_in[PC_SPARE];
               state_next.ctrl.an_enable = wdata_in[PC_AN_ENABLE];
               state_next.ctrl.force_100 = wdata_in[PC_FORCE_100];
               state_next.ctrl.force_full = wdata_in[PC_FORCE_FULL];
               state_next.advert = wdata_in[4:0];
            end
            default: begin
               // Unmapped and reserved addresses, 0x4A6 among them, ignore writes.
               state_next.spare14 = state_reg.spare14;
            end
         endcase
      end

      // Completion lands the counter value unless a new launch comes in the same cycle; then the flag stays up.
      if (counter_done && !launch_read) begin
         state_next.data = counter_data;
         state_next.reading = 1'b0;
      end
   end

   always_ff @(posedge ref_clk_in or posedge reset_in) begin
      if (reset_in) begin
         state_reg <= '0;
         state_reg.ctrl.an_enable <= 1'b1;
         state_reg.advert <= PC_ADVERT_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   counter_store counters (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .bump_in(bump_in),
      .bump_index_in(bump_index_in),
      .read_in(launch_read),
      .read_addr_in(state_next.cmd[9:0]),
      .read_data_out(counter_data),
      .read_done_out(counter_done)
   );

   lamp_mux lamps (
      .ref_clk_in(ref_clk_in),
      .reset_in(reset_in),
      .lamp_mode_high_in(state_reg.led_ctrl[LAMP_HIGH_BIT]),
      .lamp_mode_low_in(state_reg.led_ctrl[LAMP_LOW_BIT]),
      .lamps_off_in(state_reg.ctrl.no_led),
      .link_in(phy_stat_in.link_up),
      .activity_in(activity_in),
      .full_duplex_in(full_duplex_in),
      .collision_in(collision_in),
      .speed_100_in(speed_100_in),
      .lamps_out(lamps_out)
   );

   assign rdata_out = state_reg.rdata;
   assign run_out = state_reg.run;
   assign phy_ctrl_out = state_reg.ctrl;
   assign wake3_crc_out = state_reg.crc;
   assign wake3_mask_out = state_reg.mask;
endmodule

// >>> verif/wake_regs_monitor.sv
// Checker for the register bank: watches the register port, outputs and status inputs.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module wake_regs_monitor
   import wake_regs_pkg::*;
(
   input wire logic ref_clk_in, // Clock.
   input wire logic reset_in, // Reset, high.
   input wire logic [11:0] addr_in, // Address.
   input wire logic [15:0] wdata_in, // Write data.
   input wire logic wr_in, // Write strobe.
   input wire logic rd_in, // Read strobe.
   input phy_stat_t phy_stat_in, // Live status.
   input logic [15:0] rdata_out, // Read data.
   input logic run_out, // Run control.
   input phy_ctrl_t phy_ctrl_out, // PHY control.
   input logic [31:0] wake3_crc_out, // Expected CRC.
   input logic [63:0] wake3_mask_out, // Byte mask.
   input lamps_t lamps_out // Lamps.
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);

   property p_crc_low;
      wr_in && addr_in == OFS_WAKE3_CRC_LOW |=> wake3_crc_out[15:0] == $past(wdata_in);
   endproperty
   a_crc_low: assert property (p_crc_low) else $error("crc low half wrong");
   property p_mask_first;
      wr_in && addr_in == OFS_WAKE3_MASK_FIRST |=> wake3_mask_out[15:0] == $past(wdata_in);
   endproperty
   a_mask_first: assert property (p_mask_first) else $error("mask bytes 1-16 wrong");
   property p_mask_last;
      wr_in && addr_in == OFS_WAKE3_MASK_LAST |=> wake3_mask_out[63:48] == $past(wdata_in);
   endproperty
   a_mask_last: assert property (p_mask_last) else $error("mask bytes 49-64 wrong");
   property p_id;
      rd_in && addr_in == OFS_IDENTITY_AND_RUN
         |=> rdata_out[15:1] == {FAMILY_ID, CHIP_ID, REVISION_ID};
   endproperty
   a_id: assert property (p_id) else $error("identity fields wrong");
   property p_run;
      wr_in && addr_in == OFS_IDENTITY_AND_RUN |=> run_out == $past(wdata_in[0]);
   endproperty
   a_run: assert property (p_run) else $error("run control wrong");
   property p_ctrl_ro;
      rd_in && addr_in == OFS_PHY_BASIC_CONTROL |=> !rdata_out[15] && !rdata_out[10];
   endproperty
   a_ctrl_ro: assert property (p_ctrl_ro) else $error("read-only control bits set");
   property p_an;
      wr_in && addr_in == OFS_PHY_BASIC_CONTROL
         |=> phy_ctrl_out.an_enable == $past(wdata_in[12])
         && phy_ctrl_out.force_100 == $past(wdata_in[13]);
   endproperty
   a_an: assert property (p_an) else $error("negotiation control wrong");
   property p_status;
      rd_in && addr_in == OFS_PHY_BASIC_STATUS |=> rdata_out == (BS_CAPS | {10'h000,
         $past(phy_stat_in.an_done), $past(phy_stat_in.far_fault), 1'b1,
         $past(phy_stat_in.link_up), 2'b00});
   endproperty
   a_status: assert property (p_status) else $error("status wrong");
   property p_lamps_off;
      phy_ctrl_out.no_led |=> lamps_out == 4'h0;
   endproperty
   a_lamps_off: assert property (p_lamps_off) else $error("lamps lit while off");
   property p_spare;
      rd_in && addr_in == OFS_INDIRECT_DATA_SPARE |=> rdata_out == 16'h0000;
   endproperty
   a_spare: assert property (p_spare) else $error("spare data not zero");

   c_cmd: cover property (wr_in && addr_in == OFS_INDIRECT_COMMAND && wdata_in[12]);
   c_status: cover property (rd_in && addr_in == OFS_PHY_BASIC_STATUS);
   c_lamps_off: cover property (phy_ctrl_out.no_led);
endmodule

bind wake_regs wake_regs_monitor mon (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
   .phy_stat_in(phy_stat_in), .rdata_out(rdata_out), .run_out(run_out),
   .phy_ctrl_out(phy_ctrl_out), .wake3_crc_out(wake3_crc_out),
   .wake3_mask_out(wake3_mask_out), .lamps_out(lamps_out));

// >>> verif/test_wake_pattern_mib_phy_regs.sv
// Testbench for the register bank: drives the register port and status inputs.
// Assumes read data stands only in the cycle after the read strobe.
`timescale 1ns/1ps
module test_wake_pattern_mib_phy_regs
   import wake_regs_pkg::*;
;
   logic ref_clk_in, reset_in, wr_in, rd_in, bump_in, run_out;
   logic activity_in, collision_in, speed_100_in, full_duplex_in;
   logic [11:0] addr_in;
   logic [15:0] wdata_in, rdata_out;
   logic [4:0] bump_index_in;
   logic [31:0] crc;
   logic [63:0] mask;
   phy_stat_t phy_stat_in;
   phy_ctrl_t phy_ctrl_out;
   lamps_t lamps_out;
   int error_cnt = 0;
   int n_compared = 0;

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   $display("wrong value %s expected %h seen %h", nm, e, g); error_cnt++; end end

   wake_regs dut (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .bump_in(bump_in),
      .bump_index_in(bump_index_in), .phy_stat_in(phy_stat_in), .activity_in(activity_in),
      .collision_in(collision_in), .speed_100_in(speed_100_in),
      .full_duplex_in(full_duplex_in), .rdata_out(rdata_out), .run_out(run_out),
      .phy_ctrl_out(phy_ctrl_out), .wake3_crc_out(crc), .wake3_mask_out(mask),
      .lamps_out(lamps_out));

   initial begin
      ref_clk_in = 1'b0;
      forever #5 ref_clk_in = ~ref_clk_in;
   end

   // Each task starts and ends just after a rising edge; the idle cycle between
   // strobes keeps a strobe from being lowered and raised in one time step.
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge ref_clk_in);
      wr_in <= 1'b0;
      @(posedge ref_clk_in);
   endtask

   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge ref_clk_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
      @(posedge ref_clk_in);
   endtask

   task automatic rc(input logic [11:0] a, input logic [15:0] e, input string nm);
      logic [15:0] d;
      rd(a, d);
      `CHK(nm, e, d)
   endtask

   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic t_reset();
      `CHK("control out", 11'h200, phy_ctrl_out)
      rc(OFS_PHY_BASIC_CONTROL, 16'h1000, "control");
      rc(OFS_PHY_BASIC_STATUS, 16'h7808, "status");
      rc(OFS_INDIRECT_DATA_15_0, 16'h0000, "data low");
      $display("reset test done");
   endtask

   task automatic t_wake();
      for (int i = 0; i < 6; i++) begin
         wr(OFS_WAKE3_CRC_LOW + 12'(2 * i), 16'(16'h1111 * (i + 1)));
      end
      `CHK("crc", 32'h2222_1111, crc)
      `CHK("mask", 64'h6666_5555_4444_3333, mask)
      rc(OFS_WAKE3_MASK_LAST, 16'h6666, "mask last");
      $display("wake test done");
   endtask

   task automatic t_id();
      wr(OFS_IDENTITY_AND_RUN, 16'hFFFF);
      `CHK("run", 1'b1, run_out)
      rc(OFS_IDENTITY_AND_RUN, {FAMILY_ID, CHIP_ID, REVISION_ID, 1'b1}, "id");
      wr(OFS_IDENTITY_AND_RUN, 16'h0000);
      `CHK("run", 1'b0, run_out)
      $display("identity test done");
   endtask

   task automatic t_counter();
      logic [15:0] d;
      bump_index_in <= 5'h05;
      bump_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      bump_in <= 1'b0;
      @(posedge ref_clk_in);
      wr(OFS_INDIRECT_COMMAND, 16'h1C05);
      rd(OFS_INDIRECT_READ_FLAG, d);
      `CHK("busy", 1'b1, d[7])
      for (int k = 0; k < 8 && d[7] !== 1'b0; k++) rd(OFS_INDIRECT_READ_FLAG, d);
      `CHK("busy end", 1'b0, d[7])
      rc(OFS_INDIRECT_DATA_15_0, 16'h0003, "data low");
      rc(OFS_INDIRECT_DATA_31_16, 16'h0000, "data mid");
      rc(OFS_INDIRECT_DATA_47_32, 16'h0000, "data high");
      bump_in <= 1'b1;
      @(posedge ref_clk_in);
      bump_in <= 1'b0;
      wr(OFS_INDIRECT_COMMAND, 16'h0C05);
      rc(OFS_INDIRECT_DATA_15_0, 16'h0003, "write dir");
      wr(OFS_INDIRECT_COMMAND, 16'h1005);
      rc(OFS_INDIRECT_DATA_15_0, 16'h0003, "table");
      wr(OFS_INDIRECT_DATA_47_32, 16'hA5C3);
      rc(OFS_INDIRECT_DATA_47_32, 16'hA5C3, "data high write");
      wr(OFS_INDIRECT_DATA_SPARE, 16'hFFFF);
      rc(OFS_INDIRECT_DATA_SPARE, 16'h0000, "spare");
      $display("counter test done");
   endtask

   task automatic t_phy();
      wr(OFS_PHY_BASIC_CONTROL, 16'hFFFF);
      `CHK("control out", 11'h7FF, phy_ctrl_out)
      rc(OFS_PHY_BASIC_CONTROL, 16'h7B3F, "control");
      rc(OFS_PORT_CONTROL_FOUR, 16'hFFFF, "port four");
      wr(OFS_PORT_CONTROL_FOUR, 16'h0000);
      rc(OFS_PHY_BASIC_CONTROL, 16'h0020, "alias");
      phy_stat_in <= 3'b111;
      @(posedge ref_clk_in);
      rc(OFS_PHY_BASIC_STATUS, 16'h783C, "status");
      wr(12'h300, 16'hFFFF);
      rc(12'h300, 16'h0000, "unmapped");
      $display("phy test done");
   endtask

   task automatic t_lamps();
      logic [3:0] tbl [4] = '{4'h7, 4'h5, 4'hF, 4'h0};
      phy_stat_in <= 3'b001;
      activity_in <= 1'b1;
      full_duplex_in <= 1'b1;
      speed_100_in <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         wr(OFS_GLOBAL_LED_CONTROL, {m[1], 5'h00, m[0], 9'h000});
         repeat (2) @(posedge ref_clk_in);
         `CHK("lamps", tbl[m], lamps_out)
      end
      speed_100_in <= 1'b0;
      full_duplex_in <= 1'b0;
      collision_in <= 1'b1;
      wr(OFS_GLOBAL_LED_CONTROL, 16'h0000);
      repeat (2) @(posedge ref_clk_in);
      `CHK("lamps collision", 4'h6, lamps_out)
      wr(OFS_GLOBAL_LED_CONTROL, 16'h0200);
      repeat (2) @(posedge ref_clk_in);
      `CHK("lamps 10M", 4'h2, lamps_out)
      $display("lamp test done");
   endtask

   initial begin
      #50000;
      error_cnt++;
      end_sim();
   end

   initial begin
      {reset_in, wr_in, rd_in, bump_in} = 4'h8;
      {activity_in, collision_in, speed_100_in, full_duplex_in} = 4'h0;
      addr_in = 12'h000;
      wdata_in = 16'h0000;
      bump_index_in = 5'h00;
      phy_stat_in = 3'b000;
      repeat (10) @(posedge ref_clk_in);
      reset_in <= 1'b0;
      @(posedge ref_clk_in);
      t_reset();
      t_wake();
      t_id();
      t_counter();
      t_phy();
      t_lamps();
      end_sim();
   end
endmodule
